// file: src/tcr_cfg.svh
// Register offsets, bit positions and reset values of the timer register block
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// Data-space offsets
`define TCR_OFF_IRQ_FLAGS   8'h37
`define TCR_OFF_IRQ_MASK    8'h70
`define TCR_OFF_CMP_A       8'hb3
`define TCR_OFF_CMP_B       8'hb4
`define TCR_OFF_ASYNC_STAT  8'hb6

// I/O-instruction window and start of the extended space
`define TCR_IO_BASE         8'h20
`define TCR_EXT_BASE        8'h60

// Flag and mask bit positions
`define TCR_BIT_CMP_B       2
`define TCR_BIT_CMP_A       1
`define TCR_BIT_OVF         0

// Asynchronous status bit positions
`define TCR_BIT_EXT_CLK     6
`define TCR_BIT_ASYNC_SEL   5
`define TCR_BIT_CNT_BUSY    4
`define TCR_BIT_CMPA_BUSY   3
`define TCR_BIT_CMPB_BUSY   2
`define TCR_BIT_CTLA_BUSY   1
`define TCR_BIT_CTLB_BUSY   0

// Reset values
`define TCR_RST_BYTE        8'h00
`define TCR_RST_FLAGS       3'h0

`endif

// file: src/tcr_pkg.sv
// State types of the timer register block
`default_nettype none

package tcr_pkg;

  // State of one compare channel
  typedef struct packed {
    logic [7:0] value;   // Active compare value
    logic [7:0] temp;    // Holding value while async update is pending
    logic       busy;    // Update busy
    logic       match;   // Registered match pulse
  } tcr_chan_t;

  // State of the register block top
  typedef struct packed {
    logic [2:0] flags;      // Compare B, compare A, overflow
    logic [2:0] mask;       // Interrupt enables
    logic       ext_clk;    // External clock input enable
    logic       async_sel;  // Async clock select
    logic       cnt_busy;   // Counter update busy
    logic       ctla_busy;  // Control A update busy
    logic       ctlb_busy;  // Control B update busy
    logic       block;      // Suppress match on next timer clock
    logic [7:0] rdata;      // Read data
    logic [2:0] irq;        // Interrupt request levels
    logic       osc_run;    // Crystal oscillator enable
    logic       ext_buf;    // External clock buffer enable
  } tcr_regs_t;

endpackage : tcr_pkg

`default_nettype wire

// file: src/tcr_cmp_chan.sv
// One compare channel: value register, async holding stage and match detect
`timescale 1ns/10ps
`default_nettype none
`include "tcr_cfg.svh"

module tcr_cmp_chan #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk,        // System clock
  input  wire logic             reset,          // Sync reset, active high
  input  wire logic             wr,             // Software write strobe
  input  wire logic [WIDTH-1:0] wdata,          // Write data
  input  wire logic             async_mode,     // Timer runs from async clock
  input  wire logic             timer_tick,     // One pulse per timer clock
  input  wire logic [WIDTH-1:0] counter_value,  // Current counter
  input  wire logic             block_match,    // Counter was just written
  output logic      [WIDTH-1:0] value_ff,       // Active compare value
  output logic                  busy_ff,        // Update busy
  output logic                  match_ff        // Match pulse
);

  tcr_pkg::tcr_chan_t st_ff;
  tcr_pkg::tcr_chan_t nxt_st;

  // Next state: write path, async transfer, match detect
  always_comb begin
    nxt_st = st_ff;
    // Async transfer lands on the next timer clock
    if (st_ff.busy && timer_tick) begin
      nxt_st.value = st_ff.temp;
      nxt_st.busy  = 1'b0;
    end
    // A write in async mode goes to the holding stage first
    if (wr && async_mode) begin
      nxt_st.temp = wdata;
      nxt_st.busy = 1'b1;
    end else if (wr) begin
      nxt_st.value = wdata;
    end
    // Compared on every timer clock; blocked after a counter write
    nxt_st.match = timer_tick && (counter_value == st_ff.value) && !block_match;
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign value_ff = st_ff.value;
  assign busy_ff  = st_ff.busy;
  assign match_ff = st_ff.match;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_async_wr;
    wr && async_mode;
  endsequence

  sequence s_tick_no_wr;
    timer_tick && !wr;
  endsequence

  a_match_on_equal: assert property (
    timer_tick && counter_value == st_ff.value && !block_match |=> match_ff)
    else $error("compare equality gave no match");

  a_match_blocked: assert property (
    block_match |=> !match_ff)
    else $error("match seen after counter write");

  a_async_busy_set: assert property (
    s_async_wr |=> busy_ff && st_ff.temp == $past(wdata))
    else $error("async write did not set busy");

  a_async_transfer: assert property (
    busy_ff ##0 s_tick_no_wr |=> !busy_ff && value_ff == $past(st_ff.temp))
    else $error("async value not transferred on tick");

  a_sync_write: assert property (
    wr && !async_mode |=> value_ff == $past(wdata))
    else $error("sync write not stored");

endmodule : tcr_cmp_chan

`default_nettype wire

// file: src/tcr_regs.sv
// Timer compare, interrupt flag/mask and async status register block
`timescale 1ns/10ps
`default_nettype none
`include "tcr_cfg.svh"

module tcr_regs #(
  parameter int unsigned CNT_WIDTH = 8
) (
  input  wire logic                 sys_clk,           // 20 MHz system clock
  input  wire logic                 reset,             // Sync reset, active high
  input  wire logic [7:0]           bus_addr,          // Data address, or I/O address in [5:0]
  input  wire logic                 bus_io,            // Access made by an I/O instruction
  input  wire logic                 bus_wr,            // Write strobe
  input  wire logic                 bus_rd,            // Read strobe
  input  wire logic [7:0]           bus_wdata,         // Write data
  output logic      [7:0]           bus_rdata_ff,      // Read data, one cycle after read
  input  wire logic                 timer_tick,        // One pulse per timer clock
  input  wire logic [CNT_WIDTH-1:0] counter_value,     // Counter value
  input  wire logic                 counter_overflow,  // Counter wrapped at max
  input  wire logic                 bottom_reverse,    // Direction change at zero
  input  wire logic                 pwm_mode,          // A PWM mode is active
  input  wire logic                 counter_wr,        // Software wrote the counter
  input  wire logic                 ctrl_a_wr,         // Software wrote control A
  input  wire logic                 ctrl_b_wr,         // Software wrote control B
  input  wire logic                 vec_ack_cmp_b,     // Compare B vector executed
  input  wire logic                 vec_ack_cmp_a,     // Compare A vector executed
  input  wire logic                 vec_ack_ovf,       // Overflow vector executed
  output logic      [2:0]           irq_ff,            // Requests: cmp B, cmp A, overflow
  output logic                      match_a_ff,        // Compare A match to waveform A
  output logic                      match_b_ff,        // Compare B match to waveform B
  output logic                      async_clk_sel_ff,  // Timer clock from oscillator pin
  output logic                      osc_run_ff,        // Crystal oscillator enable
  output logic                      ext_clk_buf_ff     // External clock input buffer enable
);

  tcr_pkg::tcr_regs_t st_ff;
  tcr_pkg::tcr_regs_t nxt_st;

  logic [7:0]           eff_addr;
  logic                 sel_flags;
  logic                 sel_mask;
  logic                 sel_cmp_a;
  logic                 sel_cmp_b;
  logic                 sel_async;
  logic                 block_now;
  logic [CNT_WIDTH-1:0] cmp_a_value;
  logic [CNT_WIDTH-1:0] cmp_b_value;
  logic                 cmp_a_busy;
  logic                 cmp_b_busy;
  logic [2:0]           flag_set;
  logic [2:0]           flag_clr;
  logic [7:0]           async_stat;

  // Address mapping; I/O addresses cannot reach the extended space
  assign eff_addr  = bus_io ? (`TCR_IO_BASE + {2'h0, bus_addr[5:0]}) : bus_addr;
  assign sel_flags = (eff_addr == `TCR_OFF_IRQ_FLAGS);
  assign sel_mask  = !bus_io && (bus_addr == `TCR_OFF_IRQ_MASK);
  assign sel_cmp_a = !bus_io && (bus_addr == `TCR_OFF_CMP_A);
  assign sel_cmp_b = !bus_io && (bus_addr == `TCR_OFF_CMP_B);
  assign sel_async = !bus_io && (bus_addr == `TCR_OFF_ASYNC_STAT);

  // A counter write blocks this tick too if they coincide
  assign block_now = st_ff.block || counter_wr;

  // Compare channels
  tcr_cmp_chan #(
    .WIDTH (CNT_WIDTH)
  ) u_cmp_a (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .wr            (bus_wr && sel_cmp_a),
    .wdata         (bus_wdata[CNT_WIDTH-1:0]),
    .async_mode    (st_ff.async_sel),
    .timer_tick    (timer_tick),
    .counter_value (counter_value),
    .block_match   (block_now),
    .value_ff      (cmp_a_value),
    .busy_ff       (cmp_a_busy),
    .match_ff      (match_a_ff)
  );

  tcr_cmp_chan #(
    .WIDTH (CNT_WIDTH)
  ) u_cmp_b (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .wr            (bus_wr && sel_cmp_b),
    .wdata         (bus_wdata[CNT_WIDTH-1:0]),
    .async_mode    (st_ff.async_sel),
    .timer_tick    (timer_tick),
    .counter_value (counter_value),
    .block_match   (block_now),
    .value_ff      (cmp_b_value),
    .busy_ff       (cmp_b_busy),
    .match_ff      (match_b_ff)
  );

  // Flag sources; overflow source depends on the counting mode
  always_comb begin
    flag_set                 = `TCR_RST_FLAGS;
    flag_set[`TCR_BIT_CMP_B] = match_b_ff;
    flag_set[`TCR_BIT_CMP_A] = match_a_ff;
    flag_set[`TCR_BIT_OVF]   = pwm_mode ? bottom_reverse : counter_overflow;
    flag_clr                 = `TCR_RST_FLAGS;
    flag_clr[`TCR_BIT_CMP_B] = vec_ack_cmp_b;
    flag_clr[`TCR_BIT_CMP_A] = vec_ack_cmp_a;
    flag_clr[`TCR_BIT_OVF]   = vec_ack_ovf;
    if (bus_wr && sel_flags) begin
      flag_clr = flag_clr | bus_wdata[2:0];
    end
  end

  // Async status image; bit 7 unimplemented, reads zero
  always_comb begin
    async_stat                       = `TCR_RST_BYTE;
    async_stat[`TCR_BIT_EXT_CLK]     = st_ff.ext_clk;
    async_stat[`TCR_BIT_ASYNC_SEL]   = st_ff.async_sel;
    async_stat[`TCR_BIT_CNT_BUSY]    = st_ff.cnt_busy;
    async_stat[`TCR_BIT_CMPA_BUSY]   = cmp_a_busy;
    async_stat[`TCR_BIT_CMPB_BUSY]   = cmp_b_busy;
    async_stat[`TCR_BIT_CTLA_BUSY]   = st_ff.ctla_busy;
    async_stat[`TCR_BIT_CTLB_BUSY]   = st_ff.ctlb_busy;
  end

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    // Set wins over any clear in the same cycle
    nxt_st.flags = (st_ff.flags & ~flag_clr) | flag_set;
    if (bus_wr && sel_mask) begin
      nxt_st.mask = bus_wdata[2:0];
    end
    if (bus_wr && sel_async) begin
      nxt_st.ext_clk   = bus_wdata[`TCR_BIT_EXT_CLK];
      nxt_st.async_sel = bus_wdata[`TCR_BIT_ASYNC_SEL];
    end
    // Busy bits of registers held outside; transfer done at next tick
    if (timer_tick) begin
      nxt_st.cnt_busy  = 1'b0;
      nxt_st.ctla_busy = 1'b0;
      nxt_st.ctlb_busy = 1'b0;
      nxt_st.block     = 1'b0;
    end
    if (counter_wr && st_ff.async_sel) begin
      nxt_st.cnt_busy = 1'b1;
    end
    if (ctrl_a_wr && st_ff.async_sel) begin
      nxt_st.ctla_busy = 1'b1;
    end
    if (ctrl_b_wr && st_ff.async_sel) begin
      nxt_st.ctlb_busy = 1'b1;
    end
    // Held until the tick after the write, so that tick sees no match
    if (counter_wr && !timer_tick) begin
      nxt_st.block = 1'b1;
    end
    // Read data; unmapped addresses read zero
    nxt_st.rdata = `TCR_RST_BYTE;
    if (bus_rd) begin
      if (sel_flags) begin
        nxt_st.rdata = {5'h00, st_ff.flags};
      end else if (sel_mask) begin
        nxt_st.rdata = {5'h00, st_ff.mask};
      end else if (sel_cmp_a) begin
        nxt_st.rdata = 8'(cmp_a_value);
      end else if (sel_cmp_b) begin
        nxt_st.rdata = 8'(cmp_b_value);
      end else if (sel_async) begin
        nxt_st.rdata = async_stat;
      end
    end
    // Request levels follow the next flags so they change with them
    nxt_st.irq     = nxt_st.flags & nxt_st.mask;
    // Crystal runs only while the external clock input is off
    nxt_st.osc_run = nxt_st.async_sel && !nxt_st.ext_clk;
    nxt_st.ext_buf = nxt_st.async_sel && nxt_st.ext_clk;
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign bus_rdata_ff     = st_ff.rdata;
  assign irq_ff           = st_ff.irq;
  assign async_clk_sel_ff = st_ff.async_sel;
  assign osc_run_ff       = st_ff.osc_run;
  assign ext_clk_buf_ff   = st_ff.ext_buf;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_flag_w1c(int b);
    bus_wr && sel_flags && bus_wdata[b];
  endsequence

  sequence s_mask_clear(int b);
    bus_wr && sel_mask && !bus_wdata[b];
  endsequence

  a_cmpb_flag_set: assert property (
    match_b_ff |=> st_ff.flags[`TCR_BIT_CMP_B])
    else $error("compare B match did not set flag");

  a_cmpa_flag_set: assert property (
    match_a_ff |=> st_ff.flags[`TCR_BIT_CMP_A])
    else $error("compare A match did not set flag");

  a_ovf_flag_src: assert property (
    pwm_mode && bottom_reverse |=> st_ff.flags[`TCR_BIT_OVF])
    else $error("pwm bottom did not set overflow flag");

  a_ovf_not_pwm: assert property (
    !pwm_mode && counter_overflow |=> st_ff.flags[`TCR_BIT_OVF])
    else $error("overflow did not set flag");

  a_w1c_clear: assert property (
    s_flag_w1c(`TCR_BIT_OVF) ##0 !flag_set[`TCR_BIT_OVF] |=> !st_ff.flags[`TCR_BIT_OVF])
    else $error("write one did not clear overflow flag");

  a_vec_clear: assert property (
    vec_ack_cmp_a && !match_a_ff |=> !st_ff.flags[`TCR_BIT_CMP_A])
    else $error("vector did not clear compare A flag");

  a_irq_level: assert property (
    ##1 irq_ff == (st_ff.flags & st_ff.mask))
    else $error("request not equal to flag and enable");

  a_io_flags_read: assert property (
    bus_rd && bus_io && bus_addr[5:0] == 6'h17 |=> bus_rdata_ff == {5'h00, $past(st_ff.flags)})
    else $error("flag register not at I/O address");

  a_ext_no_io: assert property (
    bus_wr && bus_io |=> st_ff.mask == $past(st_ff.mask))
    else $error("extended register written by I/O access");

  a_osc_off_ext: assert property (
    ##1 st_ff.ext_clk |-> !osc_run_ff)
    else $error("crystal runs with external clock on");

  a_cnt_busy: assert property (
    counter_wr && st_ff.async_sel |=> st_ff.cnt_busy)
    else $error("counter write did not set busy");

  a_cmpb_irq_mask: assert property (
    s_mask_clear(`TCR_BIT_CMP_B) |=> !irq_ff[`TCR_BIT_CMP_B])
    else $error("compare B request with enable cleared");

  a_cmpa_irq_mask: assert property (
    s_mask_clear(`TCR_BIT_CMP_A) |=> !irq_ff[`TCR_BIT_CMP_A])
    else $error("compare A request with enable cleared");

  a_ovf_irq_mask: assert property (
    s_mask_clear(`TCR_BIT_OVF) |=> !irq_ff[`TCR_BIT_OVF])
    else $error("overflow request with enable cleared");

  a_flag_set_wins: assert property (
    s_flag_w1c(`TCR_BIT_OVF) ##0 flag_set[`TCR_BIT_OVF] |=> st_ff.flags[`TCR_BIT_OVF])
    else $error("clear won over overflow set");

  a_unmapped_zero: assert property (
    bus_rd && !(sel_flags || sel_mask || sel_cmp_a || sel_cmp_b || sel_async)
      |=> bus_rdata_ff == `TCR_RST_BYTE)
    else $error("unmapped read not zero");

  a_unimpl_zero: assert property (
    bus_rd && (sel_flags || sel_mask) |=> bus_rdata_ff[7:3] == 5'h00)
    else $error("unimplemented bits not zero");

  a_async_sel_wr: assert property (
    bus_wr && sel_async |=> async_clk_sel_ff == $past(bus_wdata[`TCR_BIT_ASYNC_SEL]))
    else $error("async select not stored");

  a_ext_buf_on: assert property (
    st_ff.async_sel && st_ff.ext_clk |-> ext_clk_buf_ff)
    else $error("external clock buffer off");

endmodule : tcr_regs

`default_nettype wire

// file: verif/tb_async_timer_compare_irq_regs.sv
// Self-checking testbench for the timer compare, flag, mask and async status registers
`timescale 1ns/10ps
`default_nettype none

module tb_async_timer_compare_irq_regs;
  // One register access: write a byte, then read back the expected byte
  typedef struct packed {
    logic       io;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } tcr_tb_row_t;

  logic        sys_clk;
  logic        reset;
  logic [7:0]  bus_addr;
  logic        bus_io;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata_ff;
  logic [7:0]  counter_value;
  logic        pwm_mode;
  logic [8:0]  side;
  logic [2:0]  irq_ff;
  logic        match_a_ff;
  logic        match_b_ff;
  logic        async_clk_sel_ff;
  logic        osc_run_ff;
  logic        ext_clk_buf_ff;
  int          n_fail;
  int          tests_run;
  tcr_tb_row_t rows [8];

  // Side pulses: 0 tick, 1 overflow, 2 bottom, 3 cnt wr, 4 ctl A, 5 ctl B, 6-8 vector acks
  tcr_regs DUT (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .bus_addr         (bus_addr),
    .bus_io           (bus_io),
    .bus_wr           (bus_wr),
    .bus_rd           (bus_rd),
    .bus_wdata        (bus_wdata),
    .bus_rdata_ff     (bus_rdata_ff),
    .timer_tick       (side[0]),
    .counter_value    (counter_value),
    .counter_overflow (side[1]),
    .bottom_reverse   (side[2]),
    .pwm_mode         (pwm_mode),
    .counter_wr       (side[3]),
    .ctrl_a_wr        (side[4]),
    .ctrl_b_wr        (side[5]),
    .vec_ack_ovf      (side[6]),
    .vec_ack_cmp_a    (side[7]),
    .vec_ack_cmp_b    (side[8]),
    .irq_ff           (irq_ff),
    .match_a_ff       (match_a_ff),
    .match_b_ff       (match_b_ff),
    .async_clk_sel_ff (async_clk_sel_ff),
    .osc_run_ff       (osc_run_ff),
    .ext_clk_buf_ff   (ext_clk_buf_ff)
  );

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Strobe held for exactly one taking edge
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_wr    <= 1'b1;
    bus_io    <= io;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_rd   <= 1'b1;
    bus_io   <= io;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata_ff, exp);
  endtask : rd

  task automatic pulse(input logic [8:0] m, input logic [7:0] cnt);
    @(posedge sys_clk);
    side          <= m;
    counter_value <= cnt;
    @(posedge sys_clk);
    side <= 9'h000;
  endtask : pulse

  // Output flags packed into one byte for comparison
  function automatic logic [7:0] outs();
    return {match_b_ff, match_a_ff, irq_ff, async_clk_sel_ff, osc_run_ff, ext_clk_buf_ff};
  endfunction : outs

  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Watchdog, far beyond the roughly 150 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end

  initial begin
    n_fail        = 0;
    tests_run     = 0;
    reset         <= 1'b1;
    bus_addr      <= 8'h00;
    bus_io        <= 1'b0;
    bus_wr        <= 1'b0;
    bus_rd        <= 1'b0;
    bus_wdata     <= 8'h00;
    counter_value <= 8'h00;
    pwm_mode      <= 1'b0;
    side          <= 9'h000;
    rows[0] = '{1'b0, 8'h70, 8'hff, 8'h07};
    rows[1] = '{1'b0, 8'hb3, 8'ha5, 8'ha5};
    rows[2] = '{1'b0, 8'hb4, 8'h5a, 8'h5a};
    rows[3] = '{1'b1, 8'hb3, 8'hff, 8'h00};
    rows[4] = '{1'b1, 8'h30, 8'hff, 8'h00};
    rows[5] = '{1'b0, 8'h40, 8'hff, 8'h00};
    rows[6] = '{1'b0, 8'hb6, 8'h9f, 8'h00};
    rows[7] = '{1'b0, 8'h37, 8'hff, 8'h00};
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk(outs(), 8'h00);
    // Reset values of all five registers
    rd(1'b0, 8'h37, 8'h00);
    rd(1'b0, 8'h70, 8'h00);
    rd(1'b0, 8'hb3, 8'h00);
    rd(1'b0, 8'hb4, 8'h00);
    rd(1'b0, 8'hb6, 8'h00);
    // Ordinary register accesses from the table
    foreach (rows[i]) begin
      wr(rows[i].io, rows[i].addr, rows[i].wdata);
      rd(rows[i].io, rows[i].addr, rows[i].rexp);
    end
    rd(1'b0, 8'hb3, 8'ha5);
    // Compare matches on two consecutive ticks
    wr(1'b0, 8'hb3, 8'h42);
    wr(1'b0, 8'hb4, 8'h43);
    pulse(9'h001, 8'h42);
    #1;
    chk(outs(), 8'h40);
    @(posedge sys_clk);
    #1;
    chk({5'h00, irq_ff}, 8'h02);
    pulse(9'h001, 8'h43);
    #1;
    chk(outs(), 8'h90);
    @(posedge sys_clk);
    #1;
    chk({5'h00, irq_ff}, 8'h06);
    // Bottom reversal ignored outside PWM, overflow counted
    pulse(9'h004, 8'h00);
    rd(1'b1, 8'h17, 8'h06);
    pulse(9'h002, 8'hff);
    rd(1'b1, 8'h17, 8'h07);
    wr(1'b0, 8'h70, 8'h02);
    #1;
    chk({5'h00, irq_ff}, 8'h02);
    wr(1'b0, 8'h70, 8'h05);
    #1;
    chk({5'h00, irq_ff}, 8'h05);
    // Write-one clears, zero bits leave flags alone
    wr(1'b1, 8'h17, 8'h00);
    rd(1'b0, 8'h37, 8'h07);
    wr(1'b1, 8'h17, 8'h01);
    rd(1'b0, 8'h37, 8'h06);
    pulse(9'h080, 8'h00);
    rd(1'b0, 8'h37, 8'h04);
    pulse(9'h100, 8'h00);
    rd(1'b0, 8'h37, 8'h00);
    pwm_mode <= 1'b1;
    pulse(9'h002, 8'hff);
    rd(1'b0, 8'h37, 8'h00);
    pulse(9'h004, 8'h00);
    rd(1'b0, 8'h37, 8'h01);
    pulse(9'h040, 8'h00);
    rd(1'b0, 8'h37, 8'h00);
    pwm_mode <= 1'b0;
    // Overflow and its write-one clear in one cycle: the set must win
    @(posedge sys_clk);
    side      <= 9'h002;
    bus_wr    <= 1'b1;
    bus_io    <= 1'b0;
    bus_addr  <= 8'h37;
    bus_wdata <= 8'h01;
    @(posedge sys_clk);
    side   <= 9'h000;
    bus_wr <= 1'b0;
    rd(1'b0, 8'h37, 8'h01);
    wr(1'b0, 8'h37, 8'h01);
    // Counter write blocks only the next tick's match
    pulse(9'h008, 8'h42);
    pulse(9'h001, 8'h42);
    #1;
    chk(outs(), 8'h00);
    rd(1'b0, 8'h37, 8'h00);
    pulse(9'h001, 8'h42);
    rd(1'b0, 8'h37, 8'h02);
    // External clock first, then async select
    wr(1'b0, 8'hb6, 8'h40);
    wr(1'b0, 8'hb6, 8'h60);
    #1;
    chk(outs(), 8'h05);
    wr(1'b0, 8'hb3, 8'h11);
    wr(1'b0, 8'hb4, 8'h22);
    pulse(9'h038, 8'h00);
    rd(1'b0, 8'hb6, 8'h7f);
    rd(1'b0, 8'hb3, 8'h42);
    pulse(9'h001, 8'h00);
    rd(1'b0, 8'hb6, 8'h60);
    rd(1'b0, 8'hb3, 8'h11);
    rd(1'b0, 8'hb4, 8'h22);
    wr(1'b0, 8'hb6, 8'h20);
    #1;
    chk(outs(), 8'h06);
    wr(1'b0, 8'hb6, 8'h00);
    wr(1'b0, 8'hb3, 8'h42);
    #1;
    chk(outs(), 8'h00);
    // Second reset in mid-run clears the set flag
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(1'b0, 8'h37, 8'h00);
    rd(1'b0, 8'hb3, 8'h00);
    test_done();
  end
endmodule : tb_async_timer_compare_irq_regs

`default_nettype wire
